// ===== design/nv_access_defines.svh
`ifndef NV_ACCESS_DEFINES_SVH
`define NV_ACCESS_DEFINES_SVH

`define NV_DATA_OFS 8'h08
`define NV_ADDR_OFS 8'h09
`define NV_CTRL_OFS 8'h88
`define NV_UNLOCK_OFS 8'h89

`define NV_BIT_RD 0
`define NV_BIT_WR 1
`define NV_BIT_PERMIT 2
`define NV_BIT_ABORT 3
`define NV_BIT_DONE 4
`define NV_CTRL_IMPL 5

`define NV_KEY1 8'h55
`define NV_KEY2 8'hAA
`define NV_DEPTH 64
`define NV_ADDR_HI_ZERO 2'h0

`define NV_CLK_MHZ 250
`define NV_PWRUP_MS 72
`define NV_PWRUP_CYC (`NV_PWRUP_MS * 1000 * `NV_CLK_MHZ)
`define NV_WRITE_US 4
`define NV_WRITE_CYC (`NV_WRITE_US * `NV_CLK_MHZ)

`endif

// ===== design/nv_access_pkg.sv
package nv_access_pkg;

    typedef struct packed {
        logic wr_en;
        logic rd_en;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sfr_req_t;

    typedef enum logic [1:0] {
        KEY_IDLE,
        KEY_GOT1,
        KEY_GOT2
    } key_state_t;

    typedef enum logic {
        PROG_IDLE,
        PROG_BUSY
    } prog_state_t;

endpackage : nv_access_pkg

// ===== design/data_eeprom_access_control.sv
// Notes on behaviour
// - control register has five bits, upper read zero
// - read and program strobes set-only, hardware clears
// - program permit cleared at power-up
// - pin or watchdog reset mid-write sets aborted_flag
// - address and data kept across aborting reset
// - write done clears strobe, sets sticky done_flag
// - unlock port stores nothing, reads zero
// - read data lands in data register next cycle
// - read data held until next read or write
// - write starts only after 55h, AAh, then strobe
// - program strobe blocked while permit is clear
// - only por, rst and cpu writes clear permit; clearing keeps write
// - no write starts during power-up timer
// - code protection leaves cpu access unchanged
// - registers at 08h, 09h, 88h, 89h
// - only 64 bytes; upper address bits must be zero
// - control bits done,abort,permit,strobe,read at 4..0
`timescale 1ns/1ns
`include "nv_access_defines.svh"

module data_eeprom_access_control #(
    parameter int unsigned PWRUP_CYCLES = `NV_PWRUP_CYC,
    parameter int unsigned WRITE_CYCLES = `NV_WRITE_CYC
) (
    input wire logic mclk,
    input wire logic por,
    input wire logic rst,
    input wire nv_access_pkg::sfr_req_t sfr_req,
    output logic [7:0] sfr_rdata,
    output logic write_busy,
    output logic done_irq
);
    import nv_access_pkg::*;

    // por: power-on reset; rst: pin or watchdog reset (both synchronous)
    typedef struct packed {
        logic [7:0] data;
        logic [7:0] addr;
        logic done;
        logic abort;
        logic permit;
        logic wr;
        logic rd;
        key_state_t key;
        prog_state_t prog;
        logic [31:0] tmr;
        logic [31:0] pwrup;
        logic [5:0] waddr;
        logic [7:0] wdata;
        logic [7:0] rdata;
        logic busy;
        logic irq;
    } state_t;

    state_t st_ff;
    state_t nxt_st;
    logic [7:0] mem [`NV_DEPTH];
    logic mem_we;
    logic in_range;
    logic key_ok;

    assign in_range = (st_ff.addr[7:6] == `NV_ADDR_HI_ZERO);
    assign key_ok = st_ff.key == KEY_GOT2 && st_ff.permit &&
        st_ff.pwrup == 32'h0 && st_ff.prog == PROG_IDLE;
    assign mem_we = st_ff.prog == PROG_BUSY && st_ff.tmr == 32'h1;

    always_ff @(posedge mclk) begin
        if (mem_we) begin
            mem[st_ff.waddr] <= st_ff.wdata;
        end
    end

    always_comb begin
        logic [7:0] ctrl_rd;
        logic set_wr;
        ctrl_rd = 8'h00;
        set_wr = 1'b0;
        nxt_st = st_ff;
        if (st_ff.pwrup != 32'h0) begin
            nxt_st.pwrup = st_ff.pwrup - 32'h1;
        end
        // read strobe completes in one cycle
        if (st_ff.rd) begin
            nxt_st.rd = 1'b0;
            // out-of-range address reads zero; data is unscrambled
            nxt_st.data = in_range ? mem[st_ff.addr[5:0]] : 8'h00;
        end
        if (st_ff.prog == PROG_BUSY) begin
            nxt_st.tmr = st_ff.tmr - 32'h1;
            if (st_ff.tmr == 32'h1) begin
                nxt_st.prog = PROG_IDLE;
                nxt_st.wr = 1'b0;
                nxt_st.done = 1'b1;
                nxt_st.abort = 1'b0;
            end
        end
        if (sfr_req.wr_en) begin
            // any non-key write to the unlock port or strobe set re-arms
            unique case (sfr_req.addr)
                `NV_DATA_OFS: nxt_st.data = sfr_req.wdata;
                `NV_ADDR_OFS: nxt_st.addr = sfr_req.wdata;
                `NV_CTRL_OFS: begin
                    // flags: done and abort write freely, set beats clear
                    if (!(st_ff.prog == PROG_BUSY && st_ff.tmr == 32'h1)) begin
                        nxt_st.done = sfr_req.wdata[`NV_BIT_DONE];
                    end
                    nxt_st.abort = sfr_req.wdata[`NV_BIT_ABORT];
                    nxt_st.permit = sfr_req.wdata[`NV_BIT_PERMIT];
                    if (sfr_req.wdata[`NV_BIT_RD]) begin
                        nxt_st.rd = 1'b1;
                    end
                    set_wr = sfr_req.wdata[`NV_BIT_WR];
                end
                default: ;
            endcase
        end
        // key detector: only consecutive unlock writes then strobe count
        if (sfr_req.wr_en) begin
            if (sfr_req.addr == `NV_UNLOCK_OFS) begin
                if (sfr_req.wdata == `NV_KEY1) begin
                    nxt_st.key = KEY_GOT1;
                end else if (sfr_req.wdata == `NV_KEY2 &&
                             st_ff.key == KEY_GOT1) begin
                    nxt_st.key = KEY_GOT2;
                end else begin
                    nxt_st.key = KEY_IDLE;
                end
            end else begin
                nxt_st.key = KEY_IDLE;
            end
        end
        if (set_wr && key_ok && in_range) begin
            nxt_st.wr = 1'b1;
            nxt_st.prog = PROG_BUSY;
            nxt_st.tmr = WRITE_CYCLES;
            nxt_st.waddr = st_ff.addr[5:0];
            nxt_st.wdata = st_ff.data;
        end
        ctrl_rd[`NV_BIT_DONE] = nxt_st.done;
        ctrl_rd[`NV_BIT_ABORT] = nxt_st.abort;
        ctrl_rd[`NV_BIT_PERMIT] = nxt_st.permit;
        ctrl_rd[`NV_BIT_WR] = nxt_st.wr;
        ctrl_rd[`NV_BIT_RD] = nxt_st.rd;
        // read data is registered, so it shows the register one cycle on
        unique case (sfr_req.addr)
            `NV_DATA_OFS: nxt_st.rdata = nxt_st.data;
            `NV_ADDR_OFS: nxt_st.rdata = nxt_st.addr;
            `NV_CTRL_OFS: nxt_st.rdata = ctrl_rd;
            default: nxt_st.rdata = 8'h00;
        endcase
        nxt_st.busy = nxt_st.prog == PROG_BUSY;
        nxt_st.irq = nxt_st.done;
    end

    always_ff @(posedge mclk) begin
        if (por) begin
            st_ff <= '0;
            st_ff.pwrup <= PWRUP_CYCLES;
        end else if (rst) begin
            // pin/watchdog reset: addr and data survive
            st_ff.abort <= st_ff.abort | (st_ff.prog == PROG_BUSY);
            st_ff.rd <= 1'b0;
            st_ff.wr <= 1'b0;
            st_ff.permit <= 1'b0;
            st_ff.key <= KEY_IDLE;
            st_ff.prog <= PROG_IDLE;
            st_ff.tmr <= 32'h0;
            st_ff.rdata <= 8'h00;
            st_ff.busy <= 1'b0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign sfr_rdata = st_ff.rdata;
    assign write_busy = st_ff.busy;
    assign done_irq = st_ff.irq;

    property p_rd_clears;
        @(posedge mclk) disable iff (rst || por)
        st_ff.rd |=> !st_ff.rd;
    endproperty
    a_rd_clears: assert property (p_rd_clears) else $error("rd stuck");

    property p_read_data;
        @(posedge mclk) disable iff (rst || por)
        (st_ff.rd && in_range) |=> st_ff.data == $past(mem[st_ff.addr[5:0]]);
    endproperty
    a_read_data: assert property (p_read_data) else $error("bad read");

    property p_no_start_unpermitted;
        @(posedge mclk) disable iff (rst || por)
        (st_ff.prog == PROG_IDLE && !st_ff.permit) |=> st_ff.prog == PROG_IDLE;
    endproperty
    a_no_start_unpermitted: assert property (p_no_start_unpermitted)
        else $error("write without permit");

    property p_no_start_pwrup;
        @(posedge mclk) disable iff (rst || por)
        (st_ff.prog == PROG_IDLE && st_ff.pwrup != 32'h0) |=> !st_ff.wr;
    endproperty
    a_no_start_pwrup: assert property (p_no_start_pwrup)
        else $error("write during power-up");

    property p_start_needs_key;
        @(posedge mclk) disable iff (rst || por)
        $rose(st_ff.wr) |-> $past(st_ff.key) == KEY_GOT2;
    endproperty
    a_start_needs_key: assert property (p_start_needs_key)
        else $error("write without unlock");

    property p_done;
        @(posedge mclk) disable iff (rst || por)
        (st_ff.prog == PROG_BUSY && st_ff.tmr == 32'h1)
            |=> !st_ff.wr && st_ff.done;
    endproperty
    a_done: assert property (p_done) else $error("done not set");

    property p_abort;
        @(posedge mclk) disable iff (por)
        (rst && st_ff.prog == PROG_BUSY) |=> st_ff.abort;
    endproperty
    a_abort: assert property (p_abort) else $error("abort missed");

    property p_keep_addr;
        @(posedge mclk) disable iff (por)
        rst |=> st_ff.addr == $past(st_ff.addr);
    endproperty
    a_keep_addr: assert property (p_keep_addr) else $error("addr lost");

    property p_upper_zero;
        @(posedge mclk) disable iff (rst || por)
        sfr_req.addr == `NV_CTRL_OFS |=> sfr_rdata[7:5] == 3'h0;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper bits");

    property p_unlock_zero;
        @(posedge mclk) disable iff (rst || por)
        sfr_req.addr == `NV_UNLOCK_OFS |=> sfr_rdata == 8'h00;
    endproperty
    a_unlock_zero: assert property (p_unlock_zero)
        else $error("unlock port not zero");

    property p_data_readback;
        @(posedge mclk) disable iff (rst || por)
        sfr_req.addr == `NV_DATA_OFS |=> sfr_rdata == st_ff.data;
    endproperty
    a_data_readback: assert property (p_data_readback)
        else $error("data register readback");

    property p_addr_readback;
        @(posedge mclk) disable iff (rst || por)
        sfr_req.addr == `NV_ADDR_OFS |=> sfr_rdata == st_ff.addr;
    endproperty
    a_addr_readback: assert property (p_addr_readback)
        else $error("address register readback");

    property p_ctrl_bits;
        @(posedge mclk) disable iff (rst || por)
        sfr_req.addr == `NV_CTRL_OFS |=> sfr_rdata[4:0] ==
            {st_ff.done, st_ff.abort, st_ff.permit, st_ff.wr, st_ff.rd};
    endproperty
    a_ctrl_bits: assert property (p_ctrl_bits)
        else $error("control bit layout");

    property p_data_hold;
        @(posedge mclk) disable iff (rst || por)
        !st_ff.rd && !(sfr_req.wr_en && sfr_req.addr == `NV_DATA_OFS)
            |=> $stable(st_ff.data);
    endproperty
    a_data_hold: assert property (p_data_hold)
        else $error("data register changed");

    property p_keep_data;
        @(posedge mclk) disable iff (por)
        rst |=> st_ff.data == $past(st_ff.data);
    endproperty
    a_keep_data: assert property (p_keep_data)
        else $error("data lost");

    property p_permit_hold;
        @(posedge mclk) disable iff (rst || por)
        st_ff.permit && !(sfr_req.wr_en && sfr_req.addr == `NV_CTRL_OFS)
            |=> st_ff.permit;
    endproperty
    a_permit_hold: assert property (p_permit_hold)
        else $error("permit cleared by hardware");

    property p_write_runs;
        @(posedge mclk) disable iff (rst || por)
        (st_ff.prog == PROG_BUSY && st_ff.tmr != 32'h1)
            |=> st_ff.prog == PROG_BUSY;
    endproperty
    a_write_runs: assert property (p_write_runs)
        else $error("write stopped early");

    property p_start_count;
        @(posedge mclk) disable iff (rst || por)
        $rose(st_ff.wr) |-> st_ff.tmr == WRITE_CYCLES;
    endproperty
    a_start_count: assert property (p_start_count)
        else $error("write timer not loaded");

    property p_tmr_bounded;
        @(posedge mclk) disable iff (rst || por)
        st_ff.prog == PROG_BUSY |->
            (st_ff.tmr != 32'h0 && st_ff.tmr <= WRITE_CYCLES);
    endproperty
    a_tmr_bounded: assert property (p_tmr_bounded)
        else $error("write timer out of range");

    property p_wr_not_cleared;
        @(posedge mclk) disable iff (rst || por)
        (st_ff.wr && st_ff.tmr != 32'h1) |=> st_ff.wr;
    endproperty
    a_wr_not_cleared: assert property (p_wr_not_cleared)
        else $error("program strobe cleared early");

    property p_rd_sets;
        @(posedge mclk) disable iff (rst || por)
        (sfr_req.wr_en && sfr_req.addr == `NV_CTRL_OFS &&
            sfr_req.wdata[`NV_BIT_RD]) |=> st_ff.rd;
    endproperty
    a_rd_sets: assert property (p_rd_sets)
        else $error("read strobe not set");

    property p_done_sticky;
        @(posedge mclk) disable iff (rst || por)
        st_ff.done && !(sfr_req.wr_en && sfr_req.addr == `NV_CTRL_OFS)
            |=> st_ff.done;
    endproperty
    a_done_sticky: assert property (p_done_sticky)
        else $error("done flag dropped");

    property p_range_refused;
        @(posedge mclk) disable iff (rst || por)
        (st_ff.prog == PROG_IDLE && st_ff.addr[7:6] != 2'h0)
            |=> st_ff.prog == PROG_IDLE;
    endproperty
    a_range_refused: assert property (p_range_refused)
        else $error("write outside implemented space");

    // no disable here: the power-on reset is the antecedent itself
    property p_por_clears;
        @(posedge mclk)
        por |=> !st_ff.permit && !st_ff.wr && st_ff.pwrup != 32'h0;
    endproperty
    a_por_clears: assert property (p_por_clears)
        else $error("permit set after power-on");

    c_write: cover property (@(posedge mclk) $fell(st_ff.wr));
    c_read: cover property (@(posedge mclk) st_ff.rd);
    c_abort: cover property (@(posedge mclk) $rose(st_ff.abort));
    c_refused: cover property (@(posedge mclk) sfr_req.wr_en &&
        sfr_req.addr == `NV_CTRL_OFS && sfr_req.wdata[`NV_BIT_WR] && !key_ok);

endmodule : data_eeprom_access_control

// ===== dv/cpu_model.sv
`timescale 1ns/1ns
module cpu_model (
    input wire logic mclk,
    output nv_access_pkg::sfr_req_t sfr_req,
    input wire logic [7:0] sfr_rdata
);
    import nv_access_pkg::*;
    initial begin
        sfr_req = '0;
    end
    // one write held for one edge; afterwards the bus shows the inverse,
    // so a design that samples late sees the wrong byte
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr_req = '{wr_en: 1'b1, rd_en: 1'b0, addr: a, wdata: d};
        @(posedge mclk);
        #1;
        sfr_req = '{wr_en: 1'b0, rd_en: 1'b0, addr: ~a, wdata: ~d};
        @(posedge mclk);
        #1;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        sfr_req = '{wr_en: 1'b0, rd_en: 1'b1, addr: a, wdata: 8'hA5};
        @(posedge mclk);
        #1;
        d = sfr_rdata;
    endtask : rd
    // nothing is ever interleaved between the keys and the strobe
    task automatic unlock(input logic [7:0] ctl);
        wr(8'h89, 8'h55);
        wr(8'h89, 8'hAA);
        wr(8'h88, ctl);
    endtask : unlock
endmodule : cpu_model

// ===== dv/data_eeprom_access_control_bench.sv
`timescale 1ns/1ns
module data_eeprom_access_control_bench;
    import nv_access_pkg::*;
    logic mclk;
    logic por;
    logic rst;
    sfr_req_t sfr_req;
    logic [7:0] sfr_rdata;
    logic write_busy;
    logic done_irq;
    int miscompares;
    int n_checks;
    logic [7:0] a;
    logic [7:0] d;
    logic [7:0] q;
    int unsigned seed;

    data_eeprom_access_control #(.PWRUP_CYCLES(20), .WRITE_CYCLES(8)) dut (
        .mclk(mclk), .por(por), .rst(rst), .sfr_req(sfr_req),
        .sfr_rdata(sfr_rdata), .write_busy(write_busy),
        .done_irq(done_irq));
    cpu_model u_cpu (.mclk(mclk), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata));

    always #2 mclk = ~mclk;

    // status byte as read: upper three bits and read strobe always zero
    function automatic logic [7:0] exp_ctrl(input logic dn, input logic ab,
                                            input logic pm, input logic wb);
        return {3'h0, dn, ab, pm, wb, 1'b0};
    endfunction : exp_ctrl
    task automatic chk(input string n, input logic [7:0] e,
                       input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic rd_chk(input string n, input logic [7:0] ad,
                          input logic [7:0] e);
        u_cpu.rd(ad, q);
        chk(n, e, q);
    endtask : rd_chk
    task automatic results();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : results
    task automatic wait_done();
        int k;
        k = 0;
        while (done_irq !== 1'b1 && k < 40) begin
            @(posedge mclk);
            #1;
            k++;
        end
        if (k == 40) begin
            miscompares++;
            $display("BAD done_irq expected 1 seen %b", done_irq);
            results();
        end
    endtask : wait_done

    initial begin
        mclk = 1'b0;
        por = 1'b1;
        rst = 1'b1;
        miscompares = 0;
        n_checks = 0;
        seed = $urandom(18997);
        repeat (6) @(posedge mclk);
        #1;
        por = 1'b0;
        rst = 1'b0;
        rd_chk("ctrl_por", 8'h88, exp_ctrl(0, 0, 0, 0));
        u_cpu.wr(8'h88, 8'h04);
        u_cpu.unlock(8'h06);
        chk("busy_pwrup", 8'h00, {7'h0, write_busy});
        rd_chk("ctrl_pwrup", 8'h88, exp_ctrl(0, 0, 1, 0));
        repeat (20) @(posedge mclk);
        #1;
        $display("test powerup done");
        u_cpu.wr(8'h88, 8'h00);
        u_cpu.unlock(8'h02);
        rd_chk("ctrl_noperm", 8'h88, exp_ctrl(0, 0, 0, 0));
        rd_chk("unlock_rd", 8'h89, 8'h00);
        rd_chk("unmapped", 8'h0A, 8'h00);
        u_cpu.wr(8'h88, 8'h04);
        u_cpu.wr(8'h89, 8'hAA);
        u_cpu.wr(8'h89, 8'h55);
        u_cpu.wr(8'h88, 8'h06);
        u_cpu.wr(8'h89, 8'h55);
        u_cpu.wr(8'h09, 8'h00);
        u_cpu.wr(8'h89, 8'hAA);
        u_cpu.wr(8'h88, 8'h06);
        rd_chk("ctrl_badseq", 8'h88, exp_ctrl(0, 0, 1, 0));
        u_cpu.wr(8'h09, 8'h40 | 8'($urandom_range(191)));
        u_cpu.unlock(8'h06);
        rd_chk("ctrl_range", 8'h88, exp_ctrl(0, 0, 1, 0));
        $display("test refusals done");
        for (int i = 0; i < 6; i++) begin
            a = (i == 1) ? 8'h3F : 8'($urandom_range(63));
            d = 8'($urandom);
            u_cpu.wr(8'h09, a);
            u_cpu.wr(8'h08, d);
            u_cpu.wr(8'h88, 8'h04);
            u_cpu.unlock(8'h06);
            chk("busy", 8'h01, {7'h0, write_busy});
            if (i == 0) begin
                // clearing permit and strobe must not stop this write
                u_cpu.wr(8'h88, 8'h00);
                rd_chk("ctrl_mid", 8'h88, exp_ctrl(0, 0, 0, 1));
            end
            wait_done();
            chk("busy_end", 8'h00, {7'h0, write_busy});
            rd_chk("ctrl_done", 8'h88, exp_ctrl(1, 0, i != 0, 0));
            rd_chk("done_hold", 8'h88, exp_ctrl(1, 0, i != 0, 0));
            u_cpu.wr(8'h88, 8'h00);
            chk("irq_clear", 8'h00, {7'h0, done_irq});
            u_cpu.wr(8'h08, ~d);
            rd_chk("data_wr", 8'h08, ~d);
            u_cpu.wr(8'h88, 8'h01);
            rd_chk("rdata", 8'h08, d);
            rd_chk("ctrl_rd", 8'h88, exp_ctrl(0, 0, 0, 0));
            rd_chk("rdata_hold", 8'h08, d);
        end
        $display("test write_read done");
        u_cpu.wr(8'h88, 8'h04);
        u_cpu.unlock(8'h06);
        rst = 1'b1;
        repeat (1 + $urandom_range(1)) @(posedge mclk);
        #1;
        rst = 1'b0;
        chk("busy_abort", 8'h00, {7'h0, write_busy});
        rd_chk("ctrl_abort", 8'h88, exp_ctrl(0, 1, 0, 0));
        rd_chk("addr_kept", 8'h09, a);
        rd_chk("data_kept", 8'h08, d);
        $display("test abort done");
        por = 1'b1;
        repeat (1 + $urandom_range(2)) @(posedge mclk);
        #1;
        por = 1'b0;
        rd_chk("ctrl_repor", 8'h88, exp_ctrl(0, 0, 0, 0));
        chk("irq_repor", 8'h00, {7'h0, done_irq});
        u_cpu.wr(8'h88, 8'h04);
        u_cpu.unlock(8'h06);
        chk("busy_repor", 8'h00, {7'h0, write_busy});
        $display("test repower done");
        results();
    end
endmodule : data_eeprom_access_control_bench
